/* divider_pkg.sv */
// Shared widths, formats and step counts of the multi-format divider
package divider_pkg;

  // Operand and result widths
  localparam int DVD_W = 16;
  localparam int DVS_W = 12;
  localparam int QUO_W = 20;
  localparam int REM_W = 8;
  localparam int OP_W  = (DVD_W > DVS_W) ? DVD_W : DVS_W;
  localparam int XW0   = (QUO_W > REM_W) ? QUO_W : REM_W;
  localparam int XW    = (XW0 > OP_W) ? XW0 : OP_W;

  // Iteration counter
  localparam int              CNT_W = $clog2(OP_W + 1);
  localparam logic [CNT_W-1:0] STEPS = CNT_W'(OP_W);
  localparam logic [CNT_W-1:0] CNT_RST = '0;

  // Number formats
  typedef enum logic [1:0] {
    ones_complement_format = 2'h0,
    twos_complement_format = 2'h1,
    sign_magnitude_format  = 2'h2,
    unsigned_format        = 2'h3
  } operand_format_t;

  localparam operand_format_t DEFAULT_FMT = twos_complement_format;

endpackage : divider_pkg

/* div_engine_if.sv */
// Handshake between the format control and the restoring engine
`timescale 1ns/1ps
interface div_engine_if;
  import divider_pkg::*;

  logic            go;
  logic [OP_W-1:0] dvd_mag;
  logic [OP_W-1:0] dvs_mag;
  logic            done;
  logic [OP_W-1:0] quo_mag;
  logic [OP_W-1:0] rem_mag;

  modport ctrl   (output go, dvd_mag, dvs_mag,
                  input  done, quo_mag, rem_mag);
  modport engine (input  go, dvd_mag, dvs_mag,
                  output done, quo_mag, rem_mag);
endinterface : div_engine_if

/* div_restoring_engine.sv */
// Unsigned restoring divider, one step per clock
`timescale 1ns/1ps
module div_restoring_engine (
  input  wire logic   clk_sys_i,
  input  wire logic   rst_n_i,
  div_engine_if.engine eng
);
  import divider_pkg::*;

  typedef enum logic [1:0] {
    e_idle = 2'b01,
    e_run  = 2'b10
  } eng_state_t;

  typedef struct packed {
    eng_state_t        st;
    logic              done;
    logic [2*OP_W-1:0] r;
    logic [2*OP_W-1:0] d;
    logic [OP_W-1:0]   b;
    logic [CNT_W-1:0]  cnt;
  } eng_s_t;

  localparam eng_s_t ENG_RST = '{e_idle, 1'b0, '0, '0, '0, CNT_RST};

  eng_s_t s_r;
  eng_s_t s_nxt;
  logic [2*OP_W+1:0] trial;

  //////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    trial = {1'b0, s_r.r, 1'b0} - {2'b00, s_r.d}; // 2R - D
    unique case (s_r.st)
      e_idle: begin
        if (eng.go) begin
          s_nxt.r   = {{OP_W{1'b0}}, eng.dvd_mag};
          s_nxt.d   = {eng.dvs_mag, {OP_W{1'b0}}};
          s_nxt.b   = '0;
          s_nxt.cnt = CNT_RST;
          s_nxt.st  = e_run;
        end
      end
      e_run: begin
        // Unknown sign counts as negative
        if (trial[2*OP_W+1] !== 1'b0) begin
          s_nxt.r = {s_r.r[2*OP_W-2:0], 1'b0};
          s_nxt.b = {s_r.b[OP_W-2:0], 1'b0};
        end else begin
          s_nxt.r = trial[2*OP_W-1:0];
          s_nxt.b = {s_r.b[OP_W-2:0], 1'b1};
        end
        s_nxt.cnt = s_r.cnt + CNT_W'(1);
        if (s_nxt.cnt == STEPS) begin
          s_nxt.st   = e_idle;
          s_nxt.done = 1'b1;
        end
      end
      default: s_nxt = ENG_RST;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= ENG_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign eng.done    = s_r.done;
  assign eng.quo_mag = s_r.b;
  assign eng.rem_mag = s_r.r[2*OP_W-1:OP_W];

  //////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  step_count_a: assert property (s_r.st == e_run |-> s_r.cnt < STEPS)
    else $error("iteration count ran past width");
  engine_load_a: assert property (
    s_r.st == e_idle && eng.go |=> s_r.cnt == CNT_RST && s_r.b == '0
      && s_r.r == {{OP_W{1'b0}}, $past(eng.dvd_mag)}
      && s_r.d == {$past(eng.dvs_mag), {OP_W{1'b0}}})
    else $error("engine load values wrong");
  divide_identity_a: assert property (
    eng.done && eng.dvs_mag != '0 |->
      (2*OP_W)'(eng.quo_mag) * (2*OP_W)'(eng.dvs_mag)
      + (2*OP_W)'(eng.rem_mag) == (2*OP_W)'(eng.dvd_mag)
      && eng.rem_mag < eng.dvs_mag)
    else $error("quotient and remainder inconsistent");

endmodule : div_restoring_engine

/* multi_format_restoring_divider.sv */
// Multi-format integer divider: format conversion and result fitting
// Function
// - Operands read and results written in the selected number format
// - Build-time parameter picks the format when no selection is given
// - Zero divisor raises divide-by-zero flag and an error pulse
// - Quotient sign found first, then operands turned into magnitudes
// - Restoring division on magnitudes, results converted back signed
// - Remainder sign follows the dividend sign, except that a zero remainder is never negative
// - Narrower operand sign-extended to the wider operand width
// - Quotient and remainder outputs have independent widths
// - Wider output gets the result sign-extended
// - Narrower output gets only the low bits of the result
// - Engine loads R with dividend, D shifted by n, clears B and count
// - Unknown operand sign bit taken as negative, then negated
// - Unknown partial remainder sign bit taken as negative
`timescale 1ns/1ps
module multi_format_restoring_divider #(
  parameter divider_pkg::operand_format_t default_operand_format =
    divider_pkg::DEFAULT_FMT
) (
  input  wire logic                          clk_sys_i,
  input  wire logic                          rstn_i,
  input  wire logic                          start_i,
  input  wire logic                          operand_format_select_en_i,
  input  wire divider_pkg::operand_format_t  operand_format_select_i,
  input  wire logic [divider_pkg::DVD_W-1:0] dividend_i,
  input  wire logic [divider_pkg::DVS_W-1:0] divisor_i,
  output logic      [divider_pkg::QUO_W-1:0] quotient_o,
  output logic      [divider_pkg::REM_W-1:0] remainder_o,
  output logic                               divide_by_zero_flag_o,
  output logic                               error_o,
  output logic                               done_o,
  output logic                               busy_o
);
  import divider_pkg::*;

  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_busy = 2'b10
  } ctrl_state_t;

  typedef struct packed {
    ctrl_state_t      st;
    logic             go;
    operand_format_t  fmt;
    logic             q_neg;
    logic             r_neg;
    logic [OP_W-1:0]  dvd_mag;
    logic [OP_W-1:0]  dvs_mag;
    logic [QUO_W-1:0] quo;
    logic [REM_W-1:0] rem;
    logic             dbz;
    logic             err;
    logic             done;
  } ctrl_s_t;

  localparam ctrl_s_t CTRL_RST = '{st_idle, 1'b0, DEFAULT_FMT, 1'b0,
    1'b0, '0, '0, '0, '0, 1'b0, 1'b0, 1'b0};

  //////////////////////////////////////////////////////////////////////
  // Format helpers

  // Sign test; unknown sign bit reads as negative
  function automatic logic is_neg(logic [OP_W-1:0] v,
                                  operand_format_t f);
    return (f != unsigned_format) && (v[OP_W-1] !== 1'b0);
  endfunction : is_neg

  // Extend a w-bit operand to the common width
  function automatic logic [OP_W-1:0] ext_op(logic [OP_W-1:0] v, int w,
                                             operand_format_t f);
    logic            s;
    logic [OP_W-1:0] r;
    s = v[w-1];
    r = v;
    for (int i = 0; i < OP_W; i++) begin
      if (i >= w) begin
        r[i] = s & (f == ones_complement_format ||
                    f == twos_complement_format);
      end
    end
    if (f == sign_magnitude_format) begin
      r[w-1]    = 1'b0;
      r[OP_W-1] = s;
    end
    return r;
  endfunction : ext_op

  // Operand to unsigned magnitude
  function automatic logic [OP_W-1:0] to_mag(logic [OP_W-1:0] v,
                                             operand_format_t f);
    logic n;
    n = is_neg(v, f);
    unique case (f)
      twos_complement_format: return n ? (~v) + OP_W'(1) : v;
      ones_complement_format: return n ? ~v : v;
      sign_magnitude_format:  return {1'b0, v[OP_W-2:0]};
      unsigned_format:        return v;
    endcase
  endfunction : to_mag

  // Magnitude and sign back to the format; zero is never negative
  function automatic logic [OP_W-1:0] to_fmt(logic [OP_W-1:0] m,
                                             logic n,
                                             operand_format_t f);
    logic neg;
    neg = n && (m != '0);
    unique case (f)
      twos_complement_format: return neg ? (~m) + OP_W'(1) : m;
      ones_complement_format: return neg ? ~m : m;
      sign_magnitude_format:  return {neg, m[OP_W-2:0]};
      unsigned_format:        return m;
    endcase
  endfunction : to_fmt

  // Fit a result into an output of width w
  function automatic logic [XW-1:0] fit_out(logic [OP_W-1:0] v,
                                            operand_format_t f, int w);
    logic [XW-1:0] r;
    r = XW'(v);
    if (w > OP_W) begin
      for (int i = OP_W; i < XW; i++) begin
        r[i] = v[OP_W-1] & (f == ones_complement_format ||
                            f == twos_complement_format);
      end
      if (f == sign_magnitude_format) begin
        r[OP_W-1] = 1'b0;
        r[w-1]    = v[OP_W-1];
      end
    end
    return r;
  endfunction : fit_out

  //////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Request decode
  ctrl_s_t         s_r;
  ctrl_s_t         s_nxt;
  operand_format_t fmt_w;
  logic [OP_W-1:0] dvd_w;
  logic [OP_W-1:0] dvs_w;
  logic            dvs_zero_w;
  logic [OP_W-1:0] quo_full_w;
  logic [OP_W-1:0] rem_full_w;
  logic [REM_W-1:0] rem_low_w;

  // Engine carrier, declared ahead of its first use
  div_engine_if eng ();

  assign fmt_w = operand_format_select_en_i ? operand_format_select_i
                                            : default_operand_format;
  assign dvd_w = ext_op(OP_W'(dividend_i), DVD_W, fmt_w);
  assign dvs_w = ext_op(OP_W'(divisor_i), DVS_W, fmt_w);
  assign dvs_zero_w = (to_mag(dvs_w, fmt_w) == '0);
  assign quo_full_w = to_fmt(eng.quo_mag, s_r.q_neg, s_r.fmt);
  assign rem_full_w = to_fmt(eng.rem_mag, s_r.r_neg, s_r.fmt);
  assign rem_low_w  = rem_full_w[REM_W-1:0];

  div_restoring_engine u_engine (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_r),
    .eng       (eng.engine)
  );

  assign eng.go      = s_r.go;
  assign eng.dvd_mag = s_r.dvd_mag;
  assign eng.dvs_mag = s_r.dvs_mag;

  //////////////////////////////////////////////////////////////////////
  // Control next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.go   = 1'b0;
    s_nxt.err  = 1'b0;
    s_nxt.done = 1'b0;
    unique case (s_r.st)
      st_idle: begin
        if (start_i) begin
          s_nxt.fmt     = fmt_w;
          s_nxt.q_neg   = is_neg(dvd_w, fmt_w) ^ is_neg(dvs_w, fmt_w);
          s_nxt.r_neg   = is_neg(dvd_w, fmt_w);
          s_nxt.dvd_mag = to_mag(dvd_w, fmt_w);
          s_nxt.dvs_mag = to_mag(dvs_w, fmt_w);
          if (dvs_zero_w) begin
            s_nxt.dbz  = 1'b1;
            s_nxt.err  = 1'b1;
            s_nxt.quo  = '0;
            s_nxt.rem  = '0;
            s_nxt.done = 1'b1;
          end else begin
            s_nxt.dbz = 1'b0;
            s_nxt.go  = 1'b1;
            s_nxt.st  = st_busy;
          end
        end
      end
      st_busy: begin
        if (eng.done) begin
          s_nxt.quo  = QUO_W'(fit_out(quo_full_w, s_r.fmt, QUO_W));
          s_nxt.rem  = REM_W'(fit_out(rem_full_w, s_r.fmt, REM_W));
          s_nxt.done = 1'b1;
          s_nxt.st   = st_idle;
        end
      end
      default: s_nxt = CTRL_RST;
    endcase
  end

  // Control register
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s_r <= CTRL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign quotient_o            = s_r.quo;
  assign remainder_o           = s_r.rem;
  assign divide_by_zero_flag_o = s_r.dbz;
  assign error_o               = s_r.err;
  assign done_o                = s_r.done;
  assign busy_o                = s_r.st[1];

  //////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_r);

  sequence accept_s;
    s_r.st == st_idle && start_i;
  endsequence

  format_default_a: assert property (
    accept_s and !operand_format_select_en_i
      |=> s_r.fmt == default_operand_format)
    else $error("default format not applied");
  zero_flag_a: assert property (
    accept_s and dvs_zero_w |=> divide_by_zero_flag_o && error_o
      && done_o && !busy_o)
    else $error("zero divisor not flagged at once");
  zero_result_a: assert property (
    done_o && divide_by_zero_flag_o |-> quotient_o == '0
      && remainder_o == '0)
    else $error("zero divisor results not cleared");
  done_pulse_a: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  done_latency_a: assert property (
    accept_s and !dvs_zero_w |-> ##1 !done_o [*7] ##12 done_o
      && !divide_by_zero_flag_o)
    else $error("division latency wrong");
  rem_sign_a: assert property (
    s_r.st == st_busy && eng.done && eng.rem_mag != '0
      && s_r.fmt == twos_complement_format
      |-> rem_full_w[OP_W-1] == dividend_i[DVD_W-1])
    else $error("remainder sign differs from dividend");
  quo_extend_a: assert property (
    done_o && s_r.fmt == twos_complement_format |->
      (&quotient_o[QUO_W-1:OP_W-1]) || !(|quotient_o[QUO_W-1:OP_W-1]))
    else $error("quotient not sign-extended");
  rem_trunc_a: assert property (
    s_r.st == st_busy && eng.done |=> remainder_o == $past(rem_low_w))
    else $error("remainder low bits wrong");

  zero_div_c:  cover property (accept_s and dvs_zero_w);
  twos_neg_c:  cover property (done_o && s_r.q_neg
    && s_r.fmt == twos_complement_format);
  sm_done_c:   cover property (done_o && !divide_by_zero_flag_o
    && s_r.fmt == sign_magnitude_format);
  uns_done_c:  cover property (done_o && s_r.fmt == unsigned_format);

endmodule : multi_format_restoring_divider

/* div_requester.sv */
// Requester model that issues division requests to the divider
`timescale 1ns/1ps
module div_requester (
  input  wire logic                     clk_sys_i,
  input  wire logic                     done_i,
  output logic                          start_o,
  output logic                          fmt_en_o,
  output divider_pkg::operand_format_t  fmt_o,
  output logic [divider_pkg::DVD_W-1:0] dividend_o,
  output logic [divider_pkg::DVS_W-1:0] divisor_o
);
  import divider_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Known values from time zero
  initial begin
    start_o    = 1'b0;
    fmt_en_o   = 1'b0;
    fmt_o      = twos_complement_format;
    dividend_o = 16'h0000;
    divisor_o  = 12'h000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle start pulse, operands and format held with it
  task automatic launch(input logic en, input operand_format_t f,
                        input logic [DVD_W-1:0] a,
                        input logic [DVS_W-1:0] d, input bit now);
    if (!now) begin
      @(posedge clk_sys_i);
      #1;
    end
    start_o    = 1'b1;
    fmt_en_o   = en;
    fmt_o      = f;
    dividend_o = a;
    divisor_o  = d;
    @(posedge clk_sys_i);
    #1;
    start_o = 1'b0;
  endtask : launch

  // Wait for done with the dividend still held; may poke a refused start
  task automatic finish(output int lat, input int poke);
    lat = 0;
    while (done_i !== 1'b1 && lat < 40) begin
      @(posedge clk_sys_i);
      #1;
      lat++;
      if (lat == poke) begin
        start_o   = 1'b1;
        divisor_o = ~divisor_o;
      end else if (lat == poke + 1) begin
        start_o = 1'b0;
      end
    end
  endtask : finish

  // Released operands show the inverse, not the last value
  task automatic release_ops;
    dividend_o = ~dividend_o;
    divisor_o  = ~divisor_o;
  endtask : release_ops
endmodule : div_requester

/* multi_format_restoring_divider_bench.sv */
// Self-checking bench for the multi-format divider
`timescale 1ns/1ps
module multi_format_restoring_divider_bench;
  import divider_pkg::*;

  logic               clk_sys_i;
  logic               rstn_i;
  logic               start;
  logic               fmt_en;
  operand_format_t    fmt;
  logic [DVD_W-1:0]   dividend;
  logic [DVS_W-1:0]   divisor;
  logic [QUO_W-1:0]   quotient_o;
  logic [REM_W-1:0]   remainder_o;
  logic               divide_by_zero_flag_o;
  logic               error_o;
  logic               done_o;
  logic               busy_o;
  int                 fails;
  int                 samples_checked;
  int                 cycles;

  ////////////////////////////////////////////////////////////////////////////
  // Design and requester
  multi_format_restoring_divider #(
    .default_operand_format(twos_complement_format)
  ) multi_format_restoring_divider_inst (
    .clk_sys_i                 (clk_sys_i),
    .rstn_i                    (rstn_i),
    .start_i                   (start),
    .operand_format_select_en_i(fmt_en),
    .operand_format_select_i   (fmt),
    .dividend_i                (dividend),
    .divisor_i                 (divisor),
    .quotient_o                (quotient_o),
    .remainder_o               (remainder_o),
    .divide_by_zero_flag_o     (divide_by_zero_flag_o),
    .error_o                   (error_o),
    .done_o                    (done_o),
    .busy_o                    (busy_o)
  );

  div_requester div_requester_inst (
    .clk_sys_i (clk_sys_i),
    .done_i    (done_o),
    .start_o   (start),
    .fmt_en_o  (fmt_en),
    .fmt_o     (fmt),
    .dividend_o(dividend),
    .divisor_o (divisor)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #2.5 clk_sys_i = ~clk_sys_i;

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 1000) begin
      fails++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparison and verdict
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  // One request and the judgement of its answer in the done cycle
  task automatic run(input logic en, input operand_format_t f,
                     input logic [DVD_W-1:0] a, input logic [DVS_W-1:0] d,
                     input logic [QUO_W-1:0] q, input logic [REM_W-1:0] r,
                     input logic z, input int poke, input bit now);
    int lat;
    div_requester_inst.launch(en, f, a, d, now);
    div_requester_inst.finish(lat, poke);
    // Edges after the taking edge: load, one per step, result register
    check("latency", z ? 0 : int'(STEPS) + 2, lat);
    check("done", 1'b1, done_o);
    check("error", z, error_o);
    check("zero flag", z, divide_by_zero_flag_o);
    check("busy", 1'b0, busy_o);
    check("quotient", q, quotient_o);
    check("remainder", r, remainder_o);
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_default;
    run(1'b0, ones_complement_format, 16'hFF9C, 12'h007, 20'hFFFF2, 8'hFE,
        1'b0, 0, 1'b0);
    div_requester_inst.release_ops();
    $display("test default format finished");
  endtask : t_default

  task automatic t_formats;
    run(1'b1, twos_complement_format, 16'h0064, 12'hFF9, 20'hFFFF2, 8'h02,
        1'b0, 0, 1'b0);
    run(1'b1, ones_complement_format, 16'hFF9B, 12'h007, 20'hFFFF1, 8'hFD,
        1'b0, 0, 1'b0);
    run(1'b1, sign_magnitude_format, 16'h8064, 12'h007, 20'h8000E, 8'h02,
        1'b0, 0, 1'b0);
    run(1'b1, sign_magnitude_format, 16'h8064, 12'h807, 20'h0000E, 8'h02,
        1'b0, 0, 1'b0);
    run(1'b1, unsigned_format, 16'hFDE8, 12'hFA0, 20'h00010, 8'hE8,
        1'b0, 0, 1'b0);
    div_requester_inst.release_ops();
    $display("test formats finished");
  endtask : t_formats

  task automatic t_zero;
    run(1'b1, twos_complement_format, 16'h1234, 12'h000, 20'h0, 8'h0,
        1'b1, 0, 1'b0);
    run(1'b1, ones_complement_format, 16'h1234, 12'hFFF, 20'h0, 8'h0,
        1'b1, 0, 1'b0);
    run(1'b1, sign_magnitude_format, 16'h1234, 12'h800, 20'h0, 8'h0,
        1'b1, 0, 1'b0);
    @(posedge clk_sys_i);
    #1;
    check("done after", 1'b0, done_o);
    check("error after", 1'b0, error_o);
    check("flag held", 1'b1, divide_by_zero_flag_o);
    run(1'b1, unsigned_format, 16'h0007, 12'h002, 20'h00003, 8'h01,
        1'b0, 0, 1'b0);
    div_requester_inst.release_ops();
    $display("test zero divisor finished");
  endtask : t_zero

  task automatic t_busy;
    // Start while busy is ignored; next start lands in the done cycle
    run(1'b1, twos_complement_format, 16'h7FFF, 12'h001, 20'h07FFF, 8'h00,
        1'b0, 5, 1'b0);
    run(1'b1, twos_complement_format, 16'h8000, 12'hFFF, 20'hF8000, 8'h00,
        1'b0, 0, 1'b1);
    div_requester_inst.release_ops();
    $display("test busy and back to back finished");
  endtask : t_busy

  task automatic t_reset;
    div_requester_inst.launch(1'b1, twos_complement_format, 16'h0100,
                              12'h003, 1'b0);
    repeat (5) @(posedge clk_sys_i);
    #1;
    check("busy running", 1'b1, busy_o);
    rstn_i = 1'b0;
    #1;
    check("busy in reset", 1'b0, busy_o);
    check("quotient in reset", 20'h0, quotient_o);
    @(posedge clk_sys_i);
    #1;
    rstn_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    run(1'b1, twos_complement_format, 16'h0009, 12'h003, 20'h00003, 8'h00,
        1'b0, 0, 1'b0);
    $display("test reset mid-run finished");
  endtask : t_reset

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clk_sys_i       = 1'b0;
    rstn_i          = 1'b0;
    fails           = 0;
    samples_checked = 0;
    cycles          = 0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    rstn_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    t_default();
    t_formats();
    t_zero();
    t_busy();
    t_reset();
    final_report();
  end
endmodule : multi_format_restoring_divider_bench
